/* File: dv/autoneg_expansion_nextpage_regs_test.sv */
`timescale 1ns/10ps
module autoneg_expansion_nextpage_regs_test;
    import an_regs_pkg::*;
    logic clock = 0, rst = 1, rd_seen = 0, override_enable = 0, par_fault_det = 0;
    logic page_stored = 0, rx_word_np = 0, flp_valid = 0, np_start = 0, base_bit11 = 0;
    logic word_sent = 0, reg_rd, reg_wr;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, np_tx_word, w, exp_q[$];
    int fail_count = 0, checks_done = 0;
    autoneg_expansion_nextpage_regs autoneg_expansion_nextpage_regs_i (.clock, .rst,
        .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .override_enable,
        .par_fault_det, .page_stored, .rx_word_np, .flp_valid, .np_start, .base_bit11,
        .word_sent, .np_tx_word);
    mgmt_station_model mgmt_station_model_i (.clock, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);
    initial forever #20 clock = ~clock;
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] e);
        checks_done++;
        if (seen !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        mgmt_station_model_i.acc(1'b0, a, 16'h0000);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) rd_seen <= reg_rd;
    always @(negedge clock) if (rd_seen) check("read data", reg_rdata, exp_q.pop_front());
    initial begin
        void'($urandom(32'hbeba_1e74));
        repeat (8) @(negedge clock);
        rst = 1'b0;
        rd(EXP_STATUS_ADDR, EXP_STATUS_RST);
        check("np word", np_tx_word, NP_TX_RST);
        override_enable = 1'($urandom);
        mgmt_station_model_i.acc(1'b1, EXP_STATUS_ADDR, 16'hffe0);
        rd(EXP_STATUS_ADDR, EXP_STATUS_RST);
        w = 16'($urandom);
        mgmt_station_model_i.acc(1'b1, NP_TX_ADDR, w);
        check("np word", np_tx_word, w & NP_TX_WMASK);
        rd(NP_TX_ADDR, w & NP_TX_WMASK);
        base_bit11 = 1'($urandom);
        pulse(np_start);
        check("toggle", {15'h0000, np_tx_word[11]}, {15'h0000, ~base_bit11});
        pulse(word_sent);
        check("toggle", {15'h0000, np_tx_word[11]}, {15'h0000, base_bit11});
        rx_word_np = 1'b1;
        pulse(par_fault_det);
        pulse(page_stored);
        pulse(flp_valid);
        rd(EXP_STATUS_ADDR, 16'h001f);
        par_fault_det = 1'b1;
        rd(EXP_STATUS_ADDR, 16'h001d);
        par_fault_det = 1'b0;
        rd(EXP_STATUS_ADDR, 16'h001d);
        rd(EXP_STATUS_ADDR, 16'h000d);
        repeat (2) @(negedge clock);
        tally_and_finish();
    end
    initial begin
        #(40 * 400);
        fail_count++;
        tally_and_finish();
    end
endmodule // autoneg_expansion_nextpage_regs_test

/* File: dv/mgmt_station_model.sv */
`timescale 1ns/10ps
module mgmt_station_model (
    input  wire logic        clock,
    output logic      [4:0]  reg_addr,
    output logic             reg_rd,
    output logic             reg_wr,
    output logic      [15:0] reg_wdata
);
    import an_regs_pkg::*;
    initial begin
        reg_addr = 5'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end
    // one access, launched and released on falling edges
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_addr <= a;
        reg_wr <= w;
        reg_rd <= !w;
        // reserved bits carry their default of zero while the access lasts; the release inverts them
        reg_wdata <= (a == EXP_STATUS_ADDR) ? {11'h000, d[4:0]} :
                     (a == NP_TX_ADDR) ? {d[15], 1'b0, d[13:0]} : d;
        @(negedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= ~reg_wdata;
    endtask
endmodule // mgmt_station_model

/* File: rtl/an_regs_pkg.sv */
package an_regs_pkg;
    localparam logic [4:0]  EXP_STATUS_ADDR = 5'h06;
    localparam logic [4:0]  NP_TX_ADDR      = 5'h07;
    localparam logic [15:0] EXP_STATUS_RST  = 16'h0004;
    localparam logic [15:0] NP_TX_RST       = 16'h2001;
    localparam int EXP_FAULT_BIT   = 4;
    localparam int EXP_LP_NP_BIT   = 3;
    localparam int EXP_LOC_NP_BIT  = 2;
    localparam int EXP_PAGE_BIT    = 1;
    localparam int EXP_LP_AN_BIT   = 0;
    localparam int NP_MORE_BIT     = 15;
    localparam int NP_MSG_BIT      = 13;
    localparam int NP_CAN_COMPLY_FLAG_BIT     = 12;
    localparam int NP_TOGGLE_BIT   = 11;
    localparam int NP_CODE_MSB     = 10;
    localparam logic [15:0] NP_TX_WMASK  = 16'hB7FF;
endpackage : an_regs_pkg

/* File: rtl/autoneg_expansion_nextpage_regs.sv */
`timescale 1ns/10ps
module autoneg_expansion_nextpage_regs (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        override_enable,
    input  wire logic        par_fault_det,
    input  wire logic        page_stored,
    input  wire logic        rx_word_np,
    input  wire logic        flp_valid,
    input  wire logic        np_start,
    input  wire logic        base_bit11,
    input  wire logic        word_sent,
    output logic      [15:0] np_tx_word
);
    import an_regs_pkg::*;

    // ***************************************************
    // decode
    // ***************************************************
    // expansion register state
    logic        fault_q;
    logic        fault_d;
    logic        page_q;
    logic        page_d;
    logic        lp_np_q;
    logic        lp_np_d;
    logic        lp_an_q;
    logic        lp_an_d;
    logic [10:0] cw_q;
    logic [10:0] cw_d;

    // next page transmit register state
    logic [15:0] np_q;
    logic [15:0] np_d;
    logic        tog_q;
    logic        tog_d;
    logic [15:0] np_word_d;

    // read path
    logic [15:0] exp_view;
    logic [15:0] np_view;
    logic [15:0] rdata_d;

    // strobes qualified by address
    wire         exp_sel = (reg_addr == EXP_STATUS_ADDR);
    wire         np_sel  = (reg_addr == NP_TX_ADDR);
    wire         exp_rd  = reg_rd && exp_sel;
    wire         np_rd   = reg_rd && np_sel;
    wire         exp_wr  = reg_wr && exp_sel;
    wire         np_wr   = reg_wr && np_sel;
    wire         exp_cw  = exp_wr && override_enable;

    // ***************************************************
    // expansion register next state
    // ***************************************************
    // a read clears the fault and page flags, but an event in the same cycle wins
    assign fault_d  = par_fault_det | (fault_q & ~exp_rd);
    assign page_d   = page_stored | (page_q & ~exp_rd);
    assign lp_np_d  = page_stored ? rx_word_np : lp_np_q;
    assign lp_an_d  = lp_an_q | flp_valid;
    // override-write bits keep what is written, yet never show on a read
    assign cw_d     = exp_cw ? reg_wdata[15:5] : cw_q;
    assign exp_view = {11'h000, fault_q, lp_np_q, 1'b1, page_q, lp_an_q};

    // ***************************************************
    // next page transmit next state
    // ***************************************************
    // reserved bit 14 and the toggle bit are not writable
    assign np_d      = np_wr ? (reg_wdata & NP_TX_WMASK) : np_q;
    // a new exchange loads the toggle and wins over a sent word in the same cycle; otherwise each sent word flips it
    assign tog_d     = np_start ? ~base_bit11 : (word_sent ? ~tog_q : tog_q);
    assign np_word_d = {np_d[NP_MORE_BIT], 1'b0, np_d[NP_MSG_BIT:NP_CAN_COMPLY_FLAG_BIT], tog_d,
                        np_d[NP_CODE_MSB:0]};
    assign np_view   = {np_q[NP_MORE_BIT], 1'b0, np_q[NP_MSG_BIT:NP_CAN_COMPLY_FLAG_BIT], tog_q,
                        np_q[NP_CODE_MSB:0]};

    // ***************************************************
    // read data select
    // ***************************************************
    // unmapped addresses leave the last read value standing
    assign rdata_d = exp_rd ? exp_view :
                     np_rd  ? np_view  : reg_rdata;

    // ***************************************************
    // registers
    // ***************************************************
    // one short block per register, all with synchronous reset
    always_ff @(posedge clock) begin
        if (rst) begin
            fault_q <= EXP_STATUS_RST[EXP_FAULT_BIT];
        end else begin
            fault_q <= fault_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            page_q <= EXP_STATUS_RST[EXP_PAGE_BIT];
        end else begin
            page_q <= page_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lp_np_q <= EXP_STATUS_RST[EXP_LP_NP_BIT];
        end else begin
            lp_np_q <= lp_np_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lp_an_q <= EXP_STATUS_RST[EXP_LP_AN_BIT];
        end else begin
            lp_an_q <= lp_an_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cw_q <= EXP_STATUS_RST[15:5];
        end else begin
            cw_q <= cw_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            np_q <= NP_TX_RST;
        end else begin
            np_q <= np_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tog_q <= NP_TX_RST[NP_TOGGLE_BIT];
        end else begin
            tog_q <= tog_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            np_tx_word <= NP_TX_RST;
        end else begin
            np_tx_word <= np_word_d;
        end
    end

    // ***************************************************
    // assertions: expansion register
    // ***************************************************
    property p_rsv;
        @(posedge clock) disable iff (rst)
            exp_rd |=> reg_rdata[15:5] == 11'h000 && reg_rdata[EXP_LOC_NP_BIT];
    endproperty
    a_rsv: assert property (p_rsv) else $error("expansion read bad");

    property p_fault;
        @(posedge clock) disable iff (rst)
            par_fault_det |=> fault_q;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not latched");

    property p_fhold;
        @(posedge clock) disable iff (rst)
            fault_q && !exp_rd |=> fault_q;
    endproperty
    a_fhold: assert property (p_fhold) else $error("fault dropped");

    property p_fclr;
        @(posedge clock) disable iff (rst)
            exp_rd && !par_fault_det |=> !fault_q;
    endproperty
    a_fclr: assert property (p_fclr) else $error("fault not cleared");

    property p_page;
        @(posedge clock) disable iff (rst)
            page_stored |=> page_q;
    endproperty
    a_page: assert property (p_page) else $error("page not latched");

    property p_pclr;
        @(posedge clock) disable iff (rst)
            exp_rd && !page_stored |=> !page_q;
    endproperty
    a_pclr: assert property (p_pclr) else $error("page not cleared");

    property p_phold;
        @(posedge clock) disable iff (rst)
            page_q && !exp_rd |=> page_q;
    endproperty
    a_phold: assert property (p_phold) else $error("page dropped");

    property p_lpnp;
        @(posedge clock) disable iff (rst)
            page_stored |=> lp_np_q == $past(rx_word_np);
    endproperty
    a_lpnp: assert property (p_lpnp) else $error("partner np wrong");

    property p_an;
        @(posedge clock) disable iff (rst)
            flp_valid |=> lp_an_q;
    endproperty
    a_an: assert property (p_an) else $error("partner an wrong");

    property p_anhold;
        @(posedge clock) disable iff (rst)
            lp_an_q |=> lp_an_q;
    endproperty
    a_anhold: assert property (p_anhold) else $error("partner an dropped");

    // override-write bits: isolated while override is low, taken while high
    property p_cw_block;
        @(posedge clock) disable iff (rst)
            exp_wr && !override_enable |=> $stable(cw_q);
    endproperty
    a_cw_block: assert property (p_cw_block) else $error("override bits changed");

    property p_cw_take;
        @(posedge clock) disable iff (rst)
            exp_cw |=> cw_q == $past(reg_wdata[15:5]);
    endproperty
    a_cw_take: assert property (p_cw_take) else $error("override write lost");

    // ***************************************************
    // assertions: next page transmit
    // ***************************************************
    property p_wr;
        @(posedge clock) disable iff (rst)
            np_wr |=> np_tx_word[NP_CODE_MSB:0] == $past(reg_wdata[NP_CODE_MSB:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("np write lost");

    property p_more;
        @(posedge clock) disable iff (rst)
            np_wr |=> np_tx_word[NP_MORE_BIT] == $past(reg_wdata[NP_MORE_BIT]);
    endproperty
    a_more: assert property (p_more) else $error("more pages bit wrong");

    property p_msg;
        @(posedge clock) disable iff (rst)
            np_wr |=> np_tx_word[NP_MSG_BIT] == $past(reg_wdata[NP_MSG_BIT]);
    endproperty
    a_msg: assert property (p_msg) else $error("message page bit wrong");

    property p_can_comply_flag;
        @(posedge clock) disable iff (rst)
            np_wr |=> np_tx_word[NP_CAN_COMPLY_FLAG_BIT] == $past(reg_wdata[NP_CAN_COMPLY_FLAG_BIT]);
    endproperty
    a_can_comply_flag: assert property (p_can_comply_flag) else $error("can comply bit wrong");

    property p_tog;
        @(posedge clock) disable iff (rst)
            word_sent && !np_start |=> tog_q != $past(tog_q);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle stuck");

    property p_tload;
        @(posedge clock) disable iff (rst)
            np_start |=> np_tx_word[NP_TOGGLE_BIT] == !$past(base_bit11);
    endproperty
    a_tload: assert property (p_tload) else $error("toggle start wrong");

    // the sent word moves only on a write or a toggle event
    property p_nphold;
        @(posedge clock) disable iff (rst)
            !np_wr && !np_start && !word_sent |=> $stable(np_tx_word);
    endproperty
    a_nphold: assert property (p_nphold) else $error("np word moved");

    property p_nprd;
        @(posedge clock) disable iff (rst)
            np_rd |=> reg_rdata == $past(np_tx_word);
    endproperty
    a_nprd: assert property (p_nprd) else $error("np read differs from sent word");

    // ***************************************************
    // covers
    // ***************************************************
    c_page:    cover property (@(posedge clock) page_stored ##1 exp_rd);
    c_tog:     cover property (@(posedge clock) np_start ##1 word_sent);
    c_wr:      cover property (@(posedge clock) np_wr);
    c_persist: cover property (@(posedge clock) par_fault_det && exp_rd);
    c_cw:      cover property (@(posedge clock) exp_cw);
endmodule : autoneg_expansion_nextpage_regs
